// file: common/gpd_pkg.sv
// Package: register map, drive codes and carrier types for the GPIO drive block
package gpd_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_A_PIN_LEVELS    = 8'h00;
    localparam logic [7:0] ADDR_PORT_B_PIN_LEVELS    = 8'h01;
    localparam logic [7:0] ADDR_PORT_A_DRIVE_SEL_LO  = 8'h0a;
    localparam logic [7:0] ADDR_PORT_A_DRIVE_SEL_HI  = 8'h0b;
    localparam logic [7:0] ADDR_PORT_B_DRIVE_SEL_LO  = 8'h0c;
    localparam logic [7:0] ADDR_PORT_B_DRIVE_SEL_HI  = 8'h0d;

    // ------------------------------------------------------------------
    // Widths, reset values, field layout
    // ------------------------------------------------------------------
    localparam int         PORT_WIDTH     = 8;
    localparam int         ADDR_WIDTH     = 8;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam int         PORT_B_MIN_PINS = 2;   // Pins 1:0 always bonded

    // Sink strength codes
    localparam logic [1:0] SINK_OFF    = 2'h0;
    localparam logic [1:0] SINK_LOW    = 2'h1;   // About 2 mA
    localparam logic [1:0] SINK_MEDIUM = 2'h2;   // About 8 mA
    localparam logic [1:0] SINK_HIGH   = 2'h3;   // About 50 mA

    // Pad controls for one pin
    typedef struct packed {
        logic       sink_en;
        logic [1:0] sink_strength;
        logic       source_en;
        logic       pullup_en;
    } gpd_pad_ctrl_type;

    // Register bus request
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [PORT_WIDTH-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } gpd_bus_req_type;

endpackage

// file: src/gpd_pin_decode.sv
// Per-pin decoder from data and drive-select bits to registered pad controls
`timescale 1ns/1ps
`default_nettype none

module gpd_pin_decode
    import gpd_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      clk_en_i,
    input  wire logic                      data_i,
    input  wire logic                      first_drive_select_i,
    input  wire logic                      second_drive_select_i,
    output gpd_pkg::gpd_pad_ctrl_type      pad_o
);
    import gpd_pkg::*;

    gpd_pad_ctrl_type pad_ff;
    gpd_pad_ctrl_type nxt_pad;

    // ------------------------------------------------------------------
    // Decode of the three configuration bits
    // ------------------------------------------------------------------
    // Each branch enables one device only, so contention is impossible
    always_comb begin
        nxt_pad = '0;
        case ({first_drive_select_i, second_drive_select_i, data_i})
            3'h2: begin
                nxt_pad.sink_en       = 1'b1;
                nxt_pad.sink_strength = SINK_LOW;
            end
            3'h4: begin
                nxt_pad.sink_en       = 1'b1;
                nxt_pad.sink_strength = SINK_MEDIUM;
            end
            3'h6: begin
                nxt_pad.sink_en       = 1'b1;
                nxt_pad.sink_strength = SINK_HIGH;
            end
            3'h5, 3'h7: nxt_pad.source_en = 1'b1;
            3'h3: nxt_pad.pullup_en = 1'b1;
            default: nxt_pad = '0;
        endcase
    end

    // Registered so pads never see decode glitches
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_ff <= '0;
        end else if (clk_en_i) begin
            pad_ff <= nxt_pad;
        end
    end

    assign pad_o = pad_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_one_device_on: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $onehot0({pad_ff.sink_en, pad_ff.source_en, pad_ff.pullup_en}))
        else $error("more than one pad device enabled");

    a_source_follows: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && first_drive_select_i && data_i) |=> pad_ff.source_en)
        else $error("source driver not enabled");

    a_high_sink: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && first_drive_select_i && second_drive_select_i && !data_i)
        |=> (pad_ff.sink_en && pad_ff.sink_strength == SINK_HIGH))
        else $error("high sink not selected");

    a_low_sink: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && !first_drive_select_i && second_drive_select_i && !data_i)
        |=> (pad_ff.sink_en && pad_ff.sink_strength == SINK_LOW))
        else $error("low sink not selected");

    a_mid_sink: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && first_drive_select_i && !second_drive_select_i && !data_i)
        |=> (pad_ff.sink_en && pad_ff.sink_strength == SINK_MEDIUM))
        else $error("medium sink not selected");

    a_pullup_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && !first_drive_select_i && second_drive_select_i && data_i)
        |=> (pad_ff.pullup_en && !pad_ff.sink_en && !pad_ff.source_en))
        else $error("pull-up mode wrong");

endmodule

`default_nettype wire

// file: src/gpd_gpio_top.sv
// Two 8-bit GPIO ports with per-pin drive configuration and register port
//
// Contract
// - Data register per port at 0x00, 0x01
// - Write-only first drive select at 0x0a/0x0c
// - Write-only second drive select at 0x0b/0x0d
// - Pin drive from data and both selects
// - Reset clears all registers, pins high-impedance
// - Both selects zero: all off, read pin
// - Second only, data zero: weak sink
// - First only, data zero: medium sink
// - Both selects, data zero: strongest sink
// - First select, data one: source only
// - Second port pins 7:2 optional
// - Every reset makes pins high-impedance
`timescale 1ns/1ps
`default_nettype none

module gpd_gpio_top
    import gpd_pkg::*;
#(
    parameter int PORT_B_PINS = 8
) (
    input  wire logic                                clock_i,
    input  wire logic                                rst_n_i,
    input  wire logic                                clk_en_i,
    input  wire gpd_pkg::gpd_bus_req_type            bus_i,
    output logic [gpd_pkg::PORT_WIDTH-1:0]           rdata_o,
    input  wire logic [gpd_pkg::PORT_WIDTH-1:0]      first_port_pins_i,
    input  wire logic [gpd_pkg::PORT_WIDTH-1:0]      second_port_pins_i,
    output gpd_pkg::gpd_pad_ctrl_type [gpd_pkg::PORT_WIDTH-1:0] first_port_pad_o,
    output gpd_pkg::gpd_pad_ctrl_type [gpd_pkg::PORT_WIDTH-1:0] second_port_pad_o
);
    import gpd_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [PORT_WIDTH-1:0] port_a_pin_levels_ff;
    logic [PORT_WIDTH-1:0] port_b_pin_levels_ff;
    logic [PORT_WIDTH-1:0] port_a_drive_sel_lo_ff;
    logic [PORT_WIDTH-1:0] port_a_drive_sel_hi_ff;
    logic [PORT_WIDTH-1:0] port_b_drive_sel_lo_ff;
    logic [PORT_WIDTH-1:0] port_b_drive_sel_hi_ff;
    logic [PORT_WIDTH-1:0] sync_a_meta_ff;
    logic [PORT_WIDTH-1:0] sync_a_ff;
    logic [PORT_WIDTH-1:0] sync_b_meta_ff;
    logic [PORT_WIDTH-1:0] sync_b_ff;
    logic [PORT_WIDTH-1:0] rdata_ff;
    logic [PORT_WIDTH-1:0] nxt_rdata;
    logic [PORT_WIDTH-1:0] port_b_mask;

    // Pins beyond the bonded count are forced inert on smaller packages
    always_comb begin
        for (int i = 0; i < PORT_WIDTH; i++) begin
            port_b_mask[i] = (i < PORT_B_PINS) || (i < PORT_B_MIN_PINS);
        end
    end

    // Address match helper, used by every register write
    function automatic logic hit(input gpd_bus_req_type req, input logic [ADDR_WIDTH-1:0] a);
        hit = req.wr && (req.addr == a);
    endfunction

    // ------------------------------------------------------------------
    // Two-stage pin synchroniser
    // ------------------------------------------------------------------
    // First stage feeds only the second, to contain metastability
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a_meta_ff <= REG_RESET;
            sync_a_ff      <= REG_RESET;
            sync_b_meta_ff <= REG_RESET;
            sync_b_ff      <= REG_RESET;
        end else if (clk_en_i) begin
            sync_a_meta_ff <= first_port_pins_i;
            sync_a_ff      <= sync_a_meta_ff;
            sync_b_meta_ff <= second_port_pins_i;
            sync_b_ff      <= sync_b_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_pin_levels_ff <= REG_RESET;
            port_b_pin_levels_ff <= REG_RESET;
        end else if (clk_en_i) begin
            if (hit(bus_i, ADDR_PORT_A_PIN_LEVELS)) begin
                port_a_pin_levels_ff <= bus_i.wdata;
            end
            if (hit(bus_i, ADDR_PORT_B_PIN_LEVELS)) begin
                port_b_pin_levels_ff <= bus_i.wdata & port_b_mask;
            end
        end
    end

    // ------------------------------------------------------------------
    // Drive-select registers, write only
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_a_drive_sel_lo_ff <= REG_RESET;
            port_a_drive_sel_hi_ff <= REG_RESET;
            port_b_drive_sel_lo_ff <= REG_RESET;
            port_b_drive_sel_hi_ff <= REG_RESET;
        end else if (clk_en_i) begin
            if (hit(bus_i, ADDR_PORT_A_DRIVE_SEL_LO)) begin
                port_a_drive_sel_lo_ff <= bus_i.wdata;
            end
            if (hit(bus_i, ADDR_PORT_B_DRIVE_SEL_LO)) begin
                port_b_drive_sel_lo_ff <= bus_i.wdata & port_b_mask;
            end
            if (hit(bus_i, ADDR_PORT_A_DRIVE_SEL_HI)) begin
                port_a_drive_sel_hi_ff <= bus_i.wdata;
            end
            if (hit(bus_i, ADDR_PORT_B_DRIVE_SEL_HI)) begin
                port_b_drive_sel_hi_ff <= bus_i.wdata & port_b_mask;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Undriven pins show the pad level, driven pins the stored bit
    always_comb begin
        nxt_rdata = '0;
        case (bus_i.addr)
            ADDR_PORT_A_PIN_LEVELS: begin
                nxt_rdata = ((port_a_drive_sel_lo_ff | port_a_drive_sel_hi_ff) & port_a_pin_levels_ff)
                          | (~(port_a_drive_sel_lo_ff | port_a_drive_sel_hi_ff) & sync_a_ff);
            end
            ADDR_PORT_B_PIN_LEVELS: begin
                nxt_rdata = (((port_b_drive_sel_lo_ff | port_b_drive_sel_hi_ff) & port_b_pin_levels_ff)
                          | (~(port_b_drive_sel_lo_ff | port_b_drive_sel_hi_ff) & sync_b_ff))
                          & port_b_mask;
            end
            default: nxt_rdata = '0;  // Write-only and unmapped read zero
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_ff <= REG_RESET;
        end else if (clk_en_i) begin
            rdata_ff <= bus_i.rd ? nxt_rdata : REG_RESET;
        end
    end

    assign rdata_o = rdata_ff;

    // ------------------------------------------------------------------
    // Per-pin decoders
    // ------------------------------------------------------------------
    // Open drain needs no mode here: software toggles first select
    for (genvar g = 0; g < PORT_WIDTH; g++) begin : g_pin
        gpd_pin_decode u_dec_a (
            .clock_i               (clock_i),
            .rst_n_i               (rst_n_i),
            .clk_en_i              (clk_en_i),
            .data_i                (port_a_pin_levels_ff[g]),
            .first_drive_select_i  (port_a_drive_sel_lo_ff[g]),
            .second_drive_select_i (port_a_drive_sel_hi_ff[g]),
            .pad_o                 (first_port_pad_o[g])
        );
        gpd_pin_decode u_dec_b (
            .clock_i               (clock_i),
            .rst_n_i               (rst_n_i),
            .clk_en_i              (clk_en_i),
            .data_i                (port_b_pin_levels_ff[g]),
            .first_drive_select_i  (port_b_drive_sel_lo_ff[g]),
            .second_drive_select_i (port_b_drive_sel_hi_ff[g]),
            .pad_o                 (second_port_pad_o[g])
        );
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_write_a_lo;
        clk_en_i && bus_i.wr && bus_i.addr == ADDR_PORT_A_DRIVE_SEL_LO;
    endsequence

    sequence s_pad_follows;
        ##2 (first_port_pad_o[0].sink_en || first_port_pad_o[0].source_en || !port_a_drive_sel_lo_ff[0]);
    endsequence

    a_reg_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.wr && bus_i.addr == ADDR_PORT_A_PIN_LEVELS)
        |=> port_a_pin_levels_ff == $past(bus_i.wdata))
        else $error("port a data not stored");

    a_sel_lo_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_write_a_lo |=> port_a_drive_sel_lo_ff == $past(bus_i.wdata))
        else $error("first drive select not stored");

    a_sel_hi_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.wr && bus_i.addr == ADDR_PORT_B_DRIVE_SEL_HI)
        |=> port_b_drive_sel_hi_ff == ($past(bus_i.wdata) & port_b_mask))
        else $error("second drive select not stored");

    a_sel_lo_pad: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (s_write_a_lo ##1 clk_en_i) |-> s_pad_follows or ##1 !clk_en_i)
        else $error("pad did not follow select");

    a_read_hiz_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.rd && bus_i.addr == ADDR_PORT_A_PIN_LEVELS
         && !port_a_drive_sel_lo_ff[0] && !port_a_drive_sel_hi_ff[0])
        |=> rdata_o[0] == $past(sync_a_ff[0]))
        else $error("high-impedance pin read wrong");

    a_rdata_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && !bus_i.rd) |=> rdata_o == '0)
        else $error("read data outside read slot");

    a_wo_reads_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.rd && bus_i.addr == ADDR_PORT_A_DRIVE_SEL_LO) |=> rdata_o == '0)
        else $error("write-only register readable");

    a_sync_depth: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((rst_n_i && clk_en_i) ##1 clk_en_i) |=> sync_a_ff == $past(first_port_pins_i, 2))
        else $error("synchroniser depth wrong");

    a_unbonded_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((port_b_drive_sel_lo_ff | port_b_drive_sel_hi_ff | port_b_pin_levels_ff) & ~port_b_mask) == '0)
        else $error("unbonded pin configured");

    // ------------------------------------------------------------------
    // Reset, enable, second-port and remaining first-port checks
    // ------------------------------------------------------------------
    // No disable here: the held reset state itself is the point
    a_reset_pads_off: assert property (@(posedge clock_i)
        !rst_n_i |-> (first_port_pad_o == '0 && second_port_pad_o == '0))
        else $error("pad driven during reset");

    a_reset_regs_clear: assert property (@(posedge clock_i)
        !rst_n_i |-> ((port_a_pin_levels_ff | port_b_pin_levels_ff
                      | port_a_drive_sel_lo_ff | port_a_drive_sel_hi_ff
                      | port_b_drive_sel_lo_ff | port_b_drive_sel_hi_ff) == REG_RESET))
        else $error("register not cleared");

    // Low enable must hold stored state and the read slot
    a_enable_freeze: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !clk_en_i |=> ($stable(port_a_pin_levels_ff) && $stable(port_a_drive_sel_hi_ff)
                       && $stable(rdata_o)))
        else $error("state moved while frozen");

    sequence s_write_b_data;
        clk_en_i && bus_i.wr && bus_i.addr == ADDR_PORT_B_PIN_LEVELS;
    endsequence

    sequence s_read_a;
        clk_en_i && bus_i.rd && bus_i.addr == ADDR_PORT_A_PIN_LEVELS;
    endsequence

    a_b_data_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_write_b_data |=> port_b_pin_levels_ff == ($past(bus_i.wdata) & port_b_mask))
        else $error("port b data not stored");

    a_a_hi_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.wr && bus_i.addr == ADDR_PORT_A_DRIVE_SEL_HI)
        |=> port_a_drive_sel_hi_ff == $past(bus_i.wdata))
        else $error("port a second select not stored");

    a_b_lo_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.wr && bus_i.addr == ADDR_PORT_B_DRIVE_SEL_LO)
        |=> port_b_drive_sel_lo_ff == ($past(bus_i.wdata) & port_b_mask))
        else $error("port b first select not stored");

    // Driven pins read back the stored bit, not the pad
    a_read_driven: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (s_read_a ##0 port_a_drive_sel_hi_ff[0]) |=> rdata_o[0] == $past(port_a_pin_levels_ff[0]))
        else $error("driven pin read wrong");

    a_read_b_hiz: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.rd && bus_i.addr == ADDR_PORT_B_PIN_LEVELS
         && !port_b_drive_sel_lo_ff[0] && !port_b_drive_sel_hi_ff[0])
        |=> rdata_o[0] == $past(sync_b_ff[0]))
        else $error("second port pin read wrong");

    a_sync_b_depth: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((rst_n_i && clk_en_i) ##1 clk_en_i) |=> sync_b_ff == $past(second_port_pins_i, 2))
        else $error("second synchroniser depth wrong");

    a_unbonded_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (clk_en_i && bus_i.rd && bus_i.addr == ADDR_PORT_B_PIN_LEVELS)
        |=> (rdata_o & ~port_b_mask) == '0)
        else $error("unbonded pin read nonzero");

    a_unbonded_pad: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        port_b_mask[PORT_WIDTH-1] || second_port_pad_o[PORT_WIDTH-1] == '0)
        else $error("unbonded pin pad driven");

endmodule

`default_nettype wire

// file: bench/gpd_pin_world.sv
// External circuitry on one port: pin level resolved from pads and outside drivers
`timescale 1ns/1ps
`default_nettype none

module gpd_pin_world
    import gpd_pkg::*;
(
    input  wire logic                                           clock_i,
    input  wire gpd_pkg::gpd_pad_ctrl_type [gpd_pkg::PORT_WIDTH-1:0] pad_i,
    input  wire logic [gpd_pkg::PORT_WIDTH-1:0]                 ext_en_i,
    input  wire logic [gpd_pkg::PORT_WIDTH-1:0]                 ext_level_i,
    output logic [gpd_pkg::PORT_WIDTH-1:0]                      pin_o
);
    // ------------------------------------------------------------------
    // Floating pins
    // ------------------------------------------------------------------
    // Undriven pin wanders every cycle, so a stale level is never read back
    logic [PORT_WIDTH-1:0] float_ff;

    initial float_ff = '0;

    always @(posedge clock_i) begin
        float_ff <= ~float_ff;
    end

    // Outside driver wins, then sink, then source or pull-up
    always_comb begin
        for (int i = 0; i < PORT_WIDTH; i++) begin
            if (ext_en_i[i]) begin
                pin_o[i] = ext_level_i[i];
            end else if (pad_i[i].sink_en) begin
                pin_o[i] = 1'b0;
            end else if (pad_i[i].source_en || pad_i[i].pullup_en) begin
                pin_o[i] = 1'b1;
            end else begin
                pin_o[i] = float_ff[i];
            end
        end
    end
endmodule

`default_nettype wire

// file: bench/gpd_gpio_top_tb.sv
// Self-checking testbench for the two-port GPIO drive block
`timescale 1ns/1ps
`default_nettype none

module gpd_gpio_top_tb;
    import gpd_pkg::*;
    // Few bonded pins on the second port, so masking is exercised
    localparam int B_PINS = 4;
    localparam logic [7:0] B_MASK = 8'h0f;

    logic                      clock_i = 1'b0;
    logic                      rst_n_i = 1'b0;
    logic                      clk_en_i = 1'b1;
    gpd_bus_req_type           bus_i = '0;
    logic [PORT_WIDTH-1:0]     rdata_o;
    logic [PORT_WIDTH-1:0]     pins_a;
    logic [PORT_WIDTH-1:0]     pins_b;
    logic [PORT_WIDTH-1:0]     ext_en_a = 8'hff;
    logic [PORT_WIDTH-1:0]     ext_lvl_a = 8'h3c;
    logic [PORT_WIDTH-1:0]     ext_en_b = 8'hff;
    logic [PORT_WIDTH-1:0]     ext_lvl_b = 8'hc3;
    gpd_pad_ctrl_type [PORT_WIDTH-1:0] pad_a;
    gpd_pad_ctrl_type [PORT_WIDTH-1:0] pad_b;
    gpd_pad_ctrl_type [PORT_WIDTH-1:0] exp_a;
    gpd_pad_ctrl_type [PORT_WIDTH-1:0] exp_b;
    logic [7:0]                rd_val;
    int                        mismatches = 0;
    int                        tests_run = 0;

    always #4 clock_i = ~clock_i;

    gpd_gpio_top #(.PORT_B_PINS(B_PINS)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .first_port_pins_i(pins_a), .second_port_pins_i(pins_b),
        .first_port_pad_o(pad_a), .second_port_pad_o(pad_b));
    gpd_pin_world world_a (.clock_i(clock_i), .pad_i(pad_a), .ext_en_i(ext_en_a), .ext_level_i(ext_lvl_a),
        .pin_o(pins_a));
    gpd_pin_world world_b (.clock_i(clock_i), .pad_i(pad_b), .ext_en_i(ext_en_b), .ext_level_i(ext_lvl_b),
        .pin_o(pins_b));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i <= '0;
    endtask

    // Read data is sampled just after the edge that takes the request
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i <= '0;
        #1;
        d = rdata_o;
    endtask

    function automatic gpd_pad_ctrl_type exp_pad(input logic d, input logic lo, input logic hi);
        exp_pad = '0;
        if (lo && d) begin
            exp_pad.source_en = 1'b1;
        end else if (hi && d) begin
            exp_pad.pullup_en = 1'b1;
        end else if (lo || hi) begin
            exp_pad.sink_en = 1'b1;
            exp_pad.sink_strength = (lo && hi) ? SINK_HIGH : (lo ? SINK_MEDIUM : SINK_LOW);
        end
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // All pads off; data reads give pin levels, write-only and unmapped read 0
    task automatic reset_state(input logic [7:0] lvl_a, input logic [7:0] lvl_b);
        logic [7:0] addrs [6];
        addrs = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h02, 8'hff};
        chk("pads_a", '0, pad_a);
        chk("pads_b", '0, pad_b);
        bus_rd(ADDR_PORT_A_PIN_LEVELS, rd_val);
        chk("read_a", lvl_a, rd_val);
        bus_rd(ADDR_PORT_B_PIN_LEVELS, rd_val);
        chk("read_b", lvl_b & B_MASK, rd_val);
        foreach (addrs[k]) begin
            bus_rd(addrs[k], rd_val);
            chk("wo_read", 8'h00, rd_val);
        end
    endtask

    // Pin i gets configuration i: data=bit0, first select=bit1, second select=bit2
    task automatic decode_table;
        @(posedge clock_i);
        ext_en_a <= 8'h03;
        ext_lvl_a <= 8'h01;
        ext_en_b <= 8'h03;
        ext_lvl_b <= 8'h01;
        bus_wr(ADDR_PORT_A_PIN_LEVELS, 8'haa);
        bus_wr(ADDR_PORT_A_DRIVE_SEL_LO, 8'hcc);
        bus_wr(ADDR_PORT_A_DRIVE_SEL_HI, 8'hf0);
        bus_wr(ADDR_PORT_B_PIN_LEVELS, 8'haa);
        bus_wr(ADDR_PORT_B_DRIVE_SEL_LO, 8'hcc);
        bus_wr(ADDR_PORT_B_DRIVE_SEL_HI, 8'hf0);
        @(posedge clock_i);
        #1;
        for (int i = 0; i < PORT_WIDTH; i++) begin
            exp_a[i] = exp_pad(i[0], i[1], i[2]);
            exp_b[i] = (i < B_PINS) ? exp_pad(i[0], i[1], i[2]) : '0;
        end
        chk("decode_a", exp_a, pad_a);
        chk("decode_b", exp_b, pad_b);
        bus_rd(ADDR_PORT_A_PIN_LEVELS, rd_val);
        chk("mixed_a", 8'ha9, rd_val);
        bus_rd(ADDR_PORT_B_PIN_LEVELS, rd_val);
        chk("mixed_b", 8'h09, rd_val);
    endtask

    // Open drain by toggling the first select; pads follow two edges after the write
    task automatic open_drain;
        bus_wr(ADDR_PORT_A_PIN_LEVELS, 8'h00);
        bus_wr(ADDR_PORT_A_DRIVE_SEL_HI, 8'h00);
        bus_wr(ADDR_PORT_A_DRIVE_SEL_LO, 8'h00);
        @(posedge clock_i);
        bus_wr(ADDR_PORT_A_DRIVE_SEL_LO, 8'h04);
        #1;
        chk("od_early", '0, pad_a);
        @(posedge clock_i);
        #1;
        exp_a = '0;
        exp_a[2] = exp_pad(1'b0, 1'b1, 1'b0);
        chk("od_sink", exp_a, pad_a);
        chk("od_pin", 1'b0, pins_a[2]);
        bus_wr(ADDR_PORT_A_DRIVE_SEL_LO, 8'h00);
        @(posedge clock_i);
        #1;
        chk("od_release", '0, pad_a);
    endtask

    // Stored data read back, read data lasts one cycle, frozen while enable is low
    task automatic data_and_enable;
        bus_wr(ADDR_PORT_A_DRIVE_SEL_HI, 8'hff);
        bus_wr(ADDR_PORT_A_PIN_LEVELS, 8'h5a);
        bus_rd(ADDR_PORT_A_PIN_LEVELS, rd_val);
        chk("data_rw", 8'h5a, rd_val);
        @(posedge clock_i);
        #1;
        chk("rdata_gone", 8'h00, rdata_o);
        @(posedge clock_i);
        clk_en_i <= 1'b0;
        bus_wr(ADDR_PORT_A_PIN_LEVELS, 8'hff);
        clk_en_i <= 1'b1;
        bus_rd(ADDR_PORT_A_PIN_LEVELS, rd_val);
        chk("frozen", 8'h5a, rd_val);
    endtask

    // Reset in mid-run: port A pads 4:0 and port B pads 2:0 checked clear at once, every register after release
    task automatic mid_reset;
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        ext_en_a <= 8'hff;
        ext_en_b <= 8'hff;
        ext_lvl_a <= 8'h96;
        ext_lvl_b <= 8'h0e;
        #1;
        chk("async_pads", '0, {pad_a[4:0], pad_b[2:0]});
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        reset_state(8'h96, 8'h0e);
    endtask

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic close_out;
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Whole run is under a hundred cycles; this limit is far beyond it
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        reset_state(8'h3c, 8'hc3);
        decode_table();
        open_drain();
        data_and_enable();
        mid_reset();
        close_out();
    end
endmodule

`default_nettype wire
